// ===== pkg/igp_defines.vh
// Timing constants for the inverter gate controller.
// Assumes a 100 MHz clock; counts are derived from times in ns.
`ifndef IGP_DEFINES_VH
`define IGP_DEFINES_VH

`define IGP_CLK_PERIOD_NS   10
// Least gap between complementary switches of one leg
`define IGP_GAP_NS          1000
`define IGP_GAP_CYC         ((`IGP_GAP_NS + `IGP_CLK_PERIOD_NS - 1) / `IGP_CLK_PERIOD_NS)
// Least on or off pulse width on any drive input
`define IGP_MINPW_NS        400
`define IGP_MINPW_CYC       ((`IGP_MINPW_NS + `IGP_CLK_PERIOD_NS - 1) / `IGP_CLK_PERIOD_NS)
// Least fault pulse the device produces
`define IGP_FAULT_NS        20000
`define IGP_FAULT_CYC       ((`IGP_FAULT_NS + `IGP_CLK_PERIOD_NS - 1) / `IGP_CLK_PERIOD_NS)
`define IGP_CNT_W           8

`endif

// ===== src/igp_leg.v
// One phase leg: gap insertion for both drives, least pulse width unless stop_i forces them off.
// Assumes the request inputs are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "igp_defines.vh"

module igp_leg #(
    parameter GAP_CYC   = `IGP_GAP_CYC,
    parameter MINPW_CYC = `IGP_MINPW_CYC
) (
    // Clock and reset
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       en_i,
    // Requests
    input  wire       high_req_i,
    input  wire       low_req_i,
    input  wire       stop_i,
    // Drives
    output reg        high_drive_o,
    output reg        low_drive_o
);
    // Counts must fit the counter width; higher bits are cut off
    localparam [`IGP_CNT_W-1:0] GAP_C = GAP_CYC[`IGP_CNT_W-1:0];
    localparam [`IGP_CNT_W-1:0] PW_C  = MINPW_CYC[`IGP_CNT_W-1:0];

    reg [`IGP_CNT_W-1:0] gap_cnt;
    reg [`IGP_CNT_W-1:0] hold_cnt;
    reg                  want_high;
    reg                  want_low;

    // Both requested together is treated as both off
    always @* begin
        want_high = high_req_i & ~low_req_i & ~stop_i;
        want_low  = low_req_i & ~high_req_i & ~stop_i;
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            high_drive_o <= 1'b0;
            low_drive_o  <= 1'b0;
            gap_cnt      <= {`IGP_CNT_W{1'b0}};
            hold_cnt     <= {`IGP_CNT_W{1'b0}};
        end else if (en_i) begin
            if (hold_cnt != {`IGP_CNT_W{1'b0}})
                hold_cnt <= hold_cnt - 8'h01;
            if (gap_cnt != {`IGP_CNT_W{1'b0}})
                gap_cnt <= gap_cnt - 8'h01;
            if (stop_i) begin
                if (high_drive_o | low_drive_o)
                    gap_cnt <= GAP_C;
                high_drive_o <= 1'b0;
                low_drive_o  <= 1'b0;
            end else if (hold_cnt == {`IGP_CNT_W{1'b0}}) begin
                if (high_drive_o != want_high && !low_drive_o) begin
                    if (!want_high || gap_cnt == {`IGP_CNT_W{1'b0}}) begin
                        high_drive_o <= want_high;
                        hold_cnt     <= PW_C;
                        if (!want_high)
                            gap_cnt <= GAP_C;
                    end
                end else if (low_drive_o != want_low && !high_drive_o) begin
                    if (!want_low || gap_cnt == {`IGP_CNT_W{1'b0}}) begin
                        low_drive_o <= want_low;
                        hold_cnt    <= PW_C;
                        if (!want_low)
                            gap_cnt <= GAP_C;
                    end
                end else if (high_drive_o && !want_high) begin
                    high_drive_o <= 1'b0;
                    hold_cnt     <= PW_C;
                    gap_cnt      <= GAP_C;
                end else if (low_drive_o && !want_low) begin
                    low_drive_o <= 1'b0;
                    hold_cnt    <= PW_C;
                    gap_cnt     <= GAP_C;
                end
            end
        end
    end
endmodule // igp_leg

`default_nettype wire

// ===== src/igp_ctrl.v
// Host-side drive controller for a three-phase inverter gate module.
// Assumes fault and temperature inputs are synchronous to clk_i.
// The open-drain fault pin is inverted to active high outside.
// Holding fault_clear_i high is allowed; a live fault still stops.
//
// Functional notes
// - Controller stops inputs when too hot.
// - Controller keeps 1us gap between complements.
// - Controller keeps pulses at least 0.4us, except on pulses cut short by a stop.
// - Drive inputs active high, low means off.
`timescale 1ns/10ps
`default_nettype none
`include "igp_defines.vh"

module igp_ctrl #(
    parameter GAP_CYC   = `IGP_GAP_CYC,
    parameter MINPW_CYC = `IGP_MINPW_CYC
) (
    // Clock, reset, enable
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       en_i,
    // PWM requests, bit 0 U, 1 V, 2 W
    input  wire [2:0] high_req_i,
    input  wire [2:0] low_req_i,
    // Module feedback
    input  wire       fault_signal_i,
    input  wire       temp_over_limit_i,
    input  wire       fault_clear_i,
    // Drive pins
    output wire       phase_u_high_drive_o,
    output wire       phase_v_high_drive_o,
    output wire       phase_w_high_drive_o,
    output wire       phase_u_low_drive_o,
    output wire       phase_v_low_drive_o,
    output wire       phase_w_low_drive_o,
    // Status
    output reg        fault_latched_o,
    output reg        stopped_o
);
    // ****************************************
    // Declarations
    // ****************************************
    // Why the legs are stopped; only RUN lets them drive
    localparam [1:0] ST_RUN  = 2'h0;
    localparam [1:0] ST_TRIP = 2'h1;
    localparam [1:0] ST_HELD = 2'h2;
    localparam [1:0] ST_HOT  = 2'h3;

    wire [2:0] high_drive;
    wire [2:0] low_drive;
    wire [2:0] leg_stop;
    reg  [1:0] state;
    reg  [1:0] next_state;
    reg        next_fault_latched;
    reg        next_stopped;

    // ****************************************
    // Stop state machine
    // ****************************************
    // A live fault beats a clear, so a fresh fault is never lost.
    // Clearing while the pin is still high has no effect.
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (fault_signal_i) begin
                    next_state = ST_TRIP;
                end else if (temp_over_limit_i) begin
                    next_state = ST_HOT;
                end else begin
                    next_state = ST_RUN;
                end
            end
            // Fault pin still high
            ST_TRIP: begin
                if (fault_signal_i) begin
                    next_state = ST_TRIP;
                end else if (!fault_clear_i) begin
                    next_state = ST_HELD;
                end else if (temp_over_limit_i) begin
                    next_state = ST_HOT;
                end else begin
                    next_state = ST_RUN;
                end
            end
            // Pin released, waiting for a clear
            ST_HELD: begin
                if (fault_signal_i) begin
                    next_state = ST_TRIP;
                end else if (!fault_clear_i) begin
                    next_state = ST_HELD;
                end else if (temp_over_limit_i) begin
                    next_state = ST_HOT;
                end else begin
                    next_state = ST_RUN;
                end
            end
            // Own thermal limit only, nothing latched
            ST_HOT: begin
                if (fault_signal_i) begin
                    next_state = ST_TRIP;
                end else if (temp_over_limit_i) begin
                    next_state = ST_HOT;
                end else begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_TRIP;
            end
        endcase
    end

    // latch held until the fault pin drops and a clear is seen; over-temperature alone latches nothing
    always @* begin
        case (next_state)
            ST_TRIP: begin
                next_fault_latched = 1'b1;
                next_stopped       = 1'b1;
            end
            ST_HELD: begin
                next_fault_latched = 1'b1;
                next_stopped       = 1'b1;
            end
            ST_HOT: begin
                next_fault_latched = 1'b0;
                next_stopped       = 1'b1;
            end
            ST_RUN: begin
                next_fault_latched = 1'b0;
                next_stopped       = 1'b0;
            end
            // Unknown code stops the legs
            default: begin
                next_fault_latched = 1'b1;
                next_stopped       = 1'b1;
            end
        endcase
    end

    // Status outputs come straight from flip-flops
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state           <= ST_RUN;
            fault_latched_o <= 1'b0;
            stopped_o       <= 1'b0;
        end else if (en_i) begin
            state           <= next_state;
            fault_latched_o <= next_fault_latched;
            stopped_o       <= next_stopped;
        end
    end

    // ****************************************
    // Phase legs with re-arm
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_leg
            wire leg_idle;
            reg  leg_armed;

            // Both requests low counts as idle
            assign leg_idle = ~(high_req_i[g] | low_req_i[g]);

            always @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    leg_armed <= 1'b1;
                end else if (en_i) begin
                    if (stopped_o) begin
                        leg_armed <= 1'b0;
                    end else if (leg_idle) begin
                        leg_armed <= 1'b1;
                    end
                end
            end

            // stopped or unarmed leg forced off
            assign leg_stop[g] = stopped_o | ~leg_armed;

            igp_leg #(
                .GAP_CYC   (GAP_CYC),
                .MINPW_CYC (MINPW_CYC)
            ) u_leg (
                .clk_i        (clk_i),
                .nrst_i       (nrst_i),
                .en_i         (en_i),
                .high_req_i   (high_req_i[g]),
                .low_req_i    (low_req_i[g]),
                .stop_i       (leg_stop[g]),
                .high_drive_o (high_drive[g]),
                .low_drive_o  (low_drive[g])
            );
        end
    endgenerate

    // ****************************************
    // Drive pins
    // ****************************************
    // high means switch on
    assign phase_u_high_drive_o = high_drive[0];
    assign phase_v_high_drive_o = high_drive[1];
    assign phase_w_high_drive_o = high_drive[2];
    assign phase_u_low_drive_o  = low_drive[0];
    assign phase_v_low_drive_o  = low_drive[1];
    assign phase_w_low_drive_o  = low_drive[2];
endmodule // igp_ctrl

`default_nettype wire

// ===== test/igp_ctrl_asserts.sv
// Port checker for the drive controller.
// Bound into igp_ctrl; leg U stands for all three legs.
`timescale 1ns/10ps
`default_nettype none
module igp_ctrl_asserts #(
    parameter int GAP_CYC   = 4,
    parameter int MINPW_CYC = 2
) (
    // Clock and inputs
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       en_i,
    input wire logic [2:0] high_req_i,
    input wire logic       temp_over_limit_i,
    // Outputs
    input wire logic       phase_u_high_drive_o,
    input wire logic       phase_u_low_drive_o,
    input wire logic       stopped_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_leg_gap: assert property (not ($fell(phase_u_high_drive_o)
        ##[0:GAP_CYC] phase_u_low_drive_o)) else $error("gap short");
    a_on_width: assert property (not ($rose(phase_u_high_drive_o)
        ##[1:MINPW_CYC] !phase_u_high_drive_o && !stopped_o))
        else $error("pulse short");
    a_hot_stop: assert property (en_i && temp_over_limit_i |=>
        stopped_o) else $error("no stop");
    a_no_self_on: assert property (en_i && !high_req_i[0] &&
        !phase_u_high_drive_o |=> !phase_u_high_drive_o)
        else $error("drive on unasked");
endmodule // igp_ctrl_asserts
bind igp_ctrl igp_ctrl_asserts #(.GAP_CYC(GAP_CYC), .MINPW_CYC(MINPW_CYC))
    u_chk (.clk_i, .nrst_i, .en_i, .high_req_i, .temp_over_limit_i,
    .phase_u_high_drive_o, .phase_u_low_drive_o, .stopped_o);
`default_nettype wire

// ===== test/igp_dev_model.sv
// Behavioural inverter module on the six drive pins.
// Fault causes come from the bench; times in clk_i cycles.
`timescale 1ns/10ps
`default_nettype none
module igp_dev_model #(parameter int FAULT_CYC = 2000) (
    // Pins: bits 0-2 high U V W, 3-5 low U V W
    input  wire logic       clk_i,
    input  wire logic [5:0] drv_i,
    // Causes
    input  wire logic       oc_i,
    input  wire logic       uv_i,
    input  wire logic       ot_i,
    input  wire logic       bs_i,
    input  wire logic       mon_i,
    // Flag, active high, and switch states
    output logic            fault_signal_o,
    output logic [5:0]      sw_o
);
    int         cnt = 0;
    logic [5:0] lock = 6'h00;
    logic       trip;
    assign trip = oc_i || uv_i || (ot_i && !mon_i);
    always @(posedge clk_i) begin
        lock <= {{3{trip}}, {3{bs_i}}}
            | (lock & (drv_i | {{3{trip || cnt != 0}}, {3{bs_i}}}));
        cnt <= trip ? FAULT_CYC : (cnt != 0 ? cnt - 1 : 0);
    end
    assign fault_signal_o = cnt != 0;
    assign sw_o = drv_i & ~lock;
endmodule // igp_dev_model
`default_nettype wire

// ===== test/test_igp_ctrl.sv
// Bench for igp_ctrl with the device model on its pins.
// Short counts: gap 4, pulse 2, flag 60 cycles.
`timescale 1ns/10ps
`default_nettype none
module test_igp_ctrl;
    logic        clk_i = 0, nrst_i = 0, en_i = 0, temp = 0, clr = 0;
    logic        oc = 0, uv = 0, ot = 0, mon = 0, bs = 0;
    logic [2:0]  hreq = 0, lreq = 0;
    wire  logic  fsig, stp, flt, uh, vh, wh, ul, vl, wl;
    wire  logic [5:0] sw;
    logic [31:0] seed = 32'h4AB7;
    int          errors = 0, checks_done = 0;
    igp_ctrl #(.GAP_CYC(4), .MINPW_CYC(2)) u_igp_ctrl (.clk_i, .nrst_i,
        .en_i, .high_req_i(hreq), .low_req_i(lreq), .fault_signal_i(fsig),
        .temp_over_limit_i(temp), .fault_clear_i(clr),
        .phase_u_high_drive_o(uh), .phase_v_high_drive_o(vh),
        .phase_w_high_drive_o(wh), .phase_u_low_drive_o(ul),
        .phase_v_low_drive_o(vl), .phase_w_low_drive_o(wl),
        .fault_latched_o(flt), .stopped_o(stp));
    igp_dev_model #(.FAULT_CYC(60)) u_igp_dev_model (.clk_i,
        .drv_i({wl, vl, ul, wh, vh, uh}), .oc_i(oc), .uv_i(uv), .ot_i(ot),
        .bs_i(bs), .mon_i(mon), .fault_signal_o(fsig), .sw_o(sw));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Clear held high: set wins while the flag stands
    task automatic recover;
        for (int i = 0; i < 200 && fsig; i++) step(1);
        step(3);
        chk("no_resume", 1'h0, ul);
        chk("latch_clr", 1'h0, flt);
        {hreq, lreq, clr} = 7'h01;
        step(2);
        clr = 1'h0;
        step(8);
        lreq = 3'h1;
        step(3);
        chk("low_back", 1'h1, ul);
    endtask
    task automatic print_verdict;
        $display("errors %0d of %0d checks", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #5 clk_i = ~clk_i;
    initial begin
        #100000;
        errors++;
        print_verdict;
    end
    initial begin
        step(4);
        nrst_i = 1'h1;
        for (int i = 0; i < 300; i++) begin
            seed = lfsr(seed);
            {en_i, lreq, hreq} = {|seed[7:6], seed[5:0]};
            step(1 + seed[10:8]);
            chk("leg", 1'h0, uh && ul || vh && vl || wh && wl);
        end
        {en_i, hreq, lreq} = 7'h40;
        step(12);
        hreq = 3'h1;
        step(2);
        chk("high_on", 1'h1, uh);
        {hreq, lreq} = 6'h01;
        step(3);
        chk("gap", 1'h0, ul);
        step(12);
        chk("low_on", 1'h1, ul);
        for (int k = 0; k < 3; k++) begin
            {oc, uv, ot} = 3'h4 >> k;
            step(4);
            chk("low_off", 1'h0, ul);
            chk("flag", 1'h1, fsig);
            chk("latched", 1'h1, flt);
            {oc, uv, ot, clr} = 4'h1;
            step(2);
            chk("stop_held", 1'h1, stp);
            recover;
        end
        {mon, ot, temp} = 3'h7;
        step(3);
        chk("hot_stop", 1'h0, ul);
        chk("no_flag", 1'h0, fsig);
        chk("no_latch", 1'h0, flt);
        {ot, temp} = 2'h0;
        recover;
        // Bootstrap trip: highs locked, no flag, lows keep running
        bs = 1'h1;
        step(3);
        chk("bs_flag", 1'h0, fsig);
        chk("bs_run", 1'h0, stp);
        chk("bs_low", 1'h1, sw[3]);
        bs = 1'h0;
        print_verdict;
    end
endmodule // test_igp_ctrl
`default_nettype wire
